// ===== bpw_bridge.sv
// bridge output steering, polarity and auto-shutdown with avalon registers
`timescale 1ns/1ps
`default_nettype none
module bpw_bridge import bpw_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// from the period timer
	input wire logic i_pwm, // raw duty waveform, high = active
	input wire logic i_period_start, // one-cycle pulse at each period start
	// shutdown sources
	input wire logic i_fault_input_pin_n,
	input wire logic i_comparator_one_output,
	input wire logic i_comparator_two_output,
	// pins, with output enables
	output logic o_out_a,
	output logic o_out_a_oe,
	output logic o_out_b,
	output logic o_out_b_oe,
	output logic o_out_c,
	output logic o_out_c_oe,
	output logic o_out_d,
	output logic o_out_d_oe,
	output logic o_period_timer_a_match_flag // first full cycle done
);
	typedef struct packed {
		bpw_state_t st; // enable sequencing
		logic [7:0] ctl; // unit_control
		logic [7:0] dbc; // dead_band_control
		logic [6:0] asc; // auto_shutdown_control low bits
		logic sd; // shutdown_status_bit
		logic [3:0] drv; // pin driver enables d..a
		logic ack; // bus answer cycle
		logic [31:0] rdata; // read data
		logic dir; // applied direction, 1 = reverse
		logic done; // full cycle complete flag
		logic hold; // output held until next period
		logic [3:0] act; // active levels d..a before polarity
		logic [1:0] tcy; // oscillator phase in instruction cycle
	} bpw_main_t;

	bpw_main_t r_reg;
	bpw_main_t r_next;

	// decode of the shutdown source field against the live levels
	function automatic logic sd_trigger(input logic [2:0] src, input logic c1,
			input logic c2, input logic flt_n);
		logic hit;
		hit = (src[0] && c1) || (src[1] && c2);
		if (src[2]) begin
			hit = hit || !flt_n;
		end
		return hit;
	endfunction

	// shared decoded configuration
	logic [1:0] mode;
	logic pwm_on;
	logic is_fb;
	logic is_half;
	logic run;
	logic cond;
	logic shut;
	logic pending;
	logic tick;
	logic db_a;
	logic db_b;
	logic req;
	logic wr_hit;
	logic [1:0] pss_ac;
	logic [1:0] pss_bd;
	logic [3:0] used;
	logic [3:0] pol;

	assign mode = r_reg.ctl[BPW_MODE_MSB:BPW_MODE_LSB];
	assign pwm_on = (r_reg.ctl[BPW_SEL_MSB:BPW_SEL_MSB-1] == BPW_PWM_SEL);
	assign is_fb = mode[0];
	assign is_half = (mode == BPW_OM_HALF);
	assign run = (r_reg.st == BPW_ST_RUN);
	assign cond = sd_trigger(r_reg.asc[BPW_SRC_MSB:BPW_SRC_LSB], i_comparator_one_output,
		i_comparator_two_output, i_fault_input_pin_n);
	// live condition joins the sticky bit so pins react in the same cycle
	assign shut = cond || r_reg.sd || r_reg.hold;
	assign pending = is_fb && (r_reg.ctl[BPW_DIR_BIT] != r_reg.dir);
	assign tick = (r_reg.tcy == 2'(BPW_OSC_PER_TCY - 1));
	assign req = i_avs_read || i_avs_write;
	assign wr_hit = i_avs_write && r_reg.ack;
	assign pss_ac = r_reg.asc[BPW_PSS_AC_MSB:BPW_PSS_AC_LSB];
	assign pss_bd = r_reg.asc[BPW_PSS_BD_MSB:BPW_PSS_BD_LSB];

	// half-bridge dead band on the true and complement paths
	bpw_deadband #(.CW(BPW_DBC_WIDTH)) u_db_a (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_en(run && is_half),
		.i_tick(tick),
		.i_count(r_reg.dbc[BPW_DBC_MSB:0]),
		.i_sig(i_pwm),
		.o_out(db_a)
	);
	bpw_deadband #(.CW(BPW_DBC_WIDTH)) u_db_b (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_en(run && is_half),
		.i_tick(tick),
		.i_count(r_reg.dbc[BPW_DBC_MSB:0]),
		.i_sig(!i_pwm),
		.o_out(db_b)
	);

	// next-state of the whole block
	always_comb begin
		r_next = r_reg;
		r_next.tcy = r_reg.tcy + 2'h1; // instruction cycle divider
		// bus: one wait state, then answer
		r_next.ack = req && !r_reg.ack;
		if (req && !r_reg.ack && i_avs_read) begin
			unique case (i_avs_address)
				BPW_OFF_UNIT_CTL: r_next.rdata = {24'h00_0000, r_reg.ctl};
				BPW_OFF_DEAD_BAND: r_next.rdata = {24'h00_0000, r_reg.dbc};
				BPW_OFF_AUTO_SD: r_next.rdata = {24'h00_0000, r_reg.sd, r_reg.asc};
				BPW_OFF_DRIVER_EN: r_next.rdata = {28'h000_0000, r_reg.drv};
				BPW_OFF_STATUS: r_next.rdata = {24'h00_0000, 2'h0, r_reg.st, r_reg.hold,
					r_reg.dir, cond, r_reg.done};
				default: r_next.rdata = 32'h0000_0000; // unmapped reads zero
			endcase
		end
		if (wr_hit) begin
			unique case (i_avs_address)
				BPW_OFF_UNIT_CTL: r_next.ctl = i_avs_writedata[7:0];
				BPW_OFF_DEAD_BAND: r_next.dbc = i_avs_writedata[7:0];
				BPW_OFF_AUTO_SD: r_next.asc = i_avs_writedata[6:0];
				BPW_OFF_DRIVER_EN: r_next.drv = i_avs_writedata[3:0];
				default: ; // status and unmapped writes dropped
			endcase
		end
		// sticky status: condition wins over any write
		if (cond) begin
			r_next.sd = 1'b1;
		end else if (wr_hit && i_avs_address == BPW_OFF_AUTO_SD) begin
			r_next.sd = i_avs_writedata[BPW_SD_STATUS_BIT];
		end else if (r_reg.dbc[BPW_RESTART_BIT] && r_reg.sd) begin
			r_next.sd = 1'b0;
		end
		// writes while cond holds never reach sd, cond branch first
		if (cond || r_reg.sd) begin
			r_next.hold = 1'b1;
		end else if (i_period_start) begin
			r_next.hold = 1'b0;
		end
		// enable sequencing
		unique case (r_reg.st)
			BPW_ST_OFF: begin
				r_next.done = 1'b0;
				if (pwm_on) begin
					r_next.st = BPW_ST_WAIT;
				end
			end
			BPW_ST_WAIT: begin
				if (!pwm_on) begin
					r_next.st = BPW_ST_OFF;
				end else if (i_period_start) begin
					r_next.st = BPW_ST_RUN;
					r_next.dir = r_reg.ctl[BPW_DIR_BIT];
				end
			end
			BPW_ST_RUN: begin
				if (!pwm_on) begin
					r_next.st = BPW_ST_OFF;
				end else if (i_period_start) begin
					r_next.done = 1'b1;
					r_next.dir = r_reg.ctl[BPW_DIR_BIT];
				end
			end
			default: r_next.st = BPW_ST_OFF;
		endcase
		// active levels a,b,c,d in bits 0..3
		r_next.act = 4'h0;
		if (run) begin
			unique case (mode)
				BPW_OM_SINGLE: r_next.act = {3'h0, i_pwm};
				BPW_OM_HALF: r_next.act = {2'h0, db_b, db_a};
				default: begin
					if (pending) begin
						// modulated off, fixed legs already swapped
						r_next.act = {1'b0, r_reg.ctl[BPW_DIR_BIT], 1'b0,
							!r_reg.ctl[BPW_DIR_BIT]};
					end else if (!r_reg.dir) begin
						r_next.act = {i_pwm, 1'b0, 1'b0, 1'b1};
					end else begin
						r_next.act = {1'b0, 1'b1, i_pwm, 1'b0};
					end
				end
			endcase
		end
	end

	// single register stage for all state
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_reg <= '{st: BPW_ST_OFF, ctl: BPW_RST_UNIT_CTL, dbc: BPW_RST_DEAD_BAND,
				asc: BPW_RST_AUTO_SD[6:0], sd: BPW_RST_AUTO_SD[7], drv: BPW_RST_DRIVER_EN,
				default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	// pins used by each mode; half-bridge leaves c and d to the port
	always_comb begin
		unique case (mode)
			BPW_OM_SINGLE: used = 4'h1;
			BPW_OM_HALF: used = 4'h3;
			default: used = 4'hf;
		endcase
	end

	// polarity per pair; changing it live glitches the pins
	assign pol = {r_reg.ctl[BPW_POL_BD_BIT], r_reg.ctl[BPW_POL_AC_BIT],
		r_reg.ctl[BPW_POL_BD_BIT], r_reg.ctl[BPW_POL_AC_BIT]};

	// pin drive: shutdown override is combinational, no clock wait
	always_comb begin
		o_out_a = shut ? pss_ac[0] : (r_reg.act[0] ^ pol[0]);
		o_out_c = shut ? pss_ac[0] : (r_reg.act[2] ^ pol[2]);
		o_out_b = shut ? pss_bd[0] : (r_reg.act[1] ^ pol[1]);
		o_out_d = shut ? pss_bd[0] : (r_reg.act[3] ^ pol[3]);
		o_out_a_oe = pwm_on && used[0] && r_reg.drv[0] && !(shut && pss_ac[1]);
		o_out_c_oe = pwm_on && used[2] && r_reg.drv[2] && !(shut && pss_ac[1]);
		o_out_b_oe = pwm_on && used[1] && r_reg.drv[1] && !(shut && pss_bd[1]);
		o_out_d_oe = pwm_on && used[3] && r_reg.drv[3] && !(shut && pss_bd[1]);
	end

	assign o_avs_waitrequest = req && !r_reg.ack;
	assign o_avs_readdata = r_reg.rdata;
	assign o_period_timer_a_match_flag = r_reg.done;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_sd_level;
		cond |=> r_reg.sd;
	endproperty
	a_sd_level: assert property (p_sd_level) else $error("shutdown lost while condition held");

	property p_fw_set;
		(wr_hit && i_avs_address == BPW_OFF_AUTO_SD && i_avs_writedata[7]) |=> r_reg.sd;
	endproperty
	a_fw_set: assert property (p_fw_set) else $error("firmware shutdown not taken");

	property p_no_clear;
		(r_reg.sd && cond) |=> r_reg.sd [*1];
	endproperty
	a_no_clear: assert property (p_no_clear) else $error("status cleared under condition");

	property p_auto_clear;
		(r_reg.dbc[7] && r_reg.sd && !cond && !wr_hit) ##1 !cond |-> !r_reg.sd;
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("auto restart did not clear");

	property p_immediate;
		(cond && o_out_a_oe) |-> (o_out_a == pss_ac[0] && o_out_b == pss_bd[0]);
	endproperty
	a_immediate: assert property (p_immediate) else $error("shutdown state not forced");

	property p_tristate;
		(shut && pss_ac[1]) |-> (!o_out_a_oe && !o_out_c_oe);
	endproperty
	a_tristate: assert property (p_tristate) else $error("pair a/c not released");

	property p_resume;
		($fell(r_reg.sd) && !i_period_start) |=> (r_reg.hold && shut);
	endproperty
	a_resume: assert property (p_resume) else $error("output resumed before period");

	property p_forward;
		(run && mode == BPW_OM_FWD && !pending && !shut && r_reg.ctl[1:0] == 2'h0)
			##1 (r_reg.ctl[1:0] == 2'h0 && !shut && !pending && run) |-> (o_out_a && !o_out_b && !o_out_c);
	endproperty
	a_forward: assert property (p_forward) else $error("forward pins wrong");

	property p_reverse;
		(run && r_reg.dir && !pending && !shut && is_fb && r_reg.ctl[1:0] == 2'h0)
			|=> (!r_reg.act[0] && r_reg.act[2] && !r_reg.act[3]);
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse pins wrong");

	property p_dir_wait;
		(run && pending && !i_period_start) |=> $stable(r_reg.dir);
	endproperty
	a_dir_wait: assert property (p_dir_wait) else $error("direction changed mid period");

	property p_change_seq;
		(run && pending) |=> (!r_reg.act[1] && !r_reg.act[3]);
	endproperty
	a_change_seq: assert property (p_change_seq) else $error("modulated legs active in change");

	property p_first_wait;
		(r_reg.st == BPW_ST_WAIT && !i_period_start) |=> (r_reg.act == 4'h0);
	endproperty
	a_first_wait: assert property (p_first_wait) else $error("output before first period");
endmodule // bpw_bridge
`default_nettype wire

// ===== bpw_deadband.sv
// rising-edge delay unit for one half-bridge output
`timescale 1ns/1ps
`default_nettype none
module bpw_deadband import bpw_pkg::*; #(
	parameter int CW = BPW_DBC_WIDTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_en, // unit active
	input wire logic i_tick, // one instruction cycle elapsed
	input wire logic [CW-1:0] i_count, // delay in instruction cycles
	input wire logic i_sig, // undelayed active level
	output logic o_out // delayed active level
);
	if (CW < 1 || CW > 16) begin : g_bad_width
		$error("bpw_deadband: unsupported count width");
	end

	typedef struct packed {
		logic [CW-1:0] cnt; // remaining delay
		logic out; // delayed output
	} bpw_db_t;

	bpw_db_t db_reg;
	bpw_db_t db_next;

	// delay only when going active; dropping out is immediate
	always_comb begin
		db_next = db_reg;
		if (!i_en || !i_sig) begin
			db_next.out = 1'b0;
			db_next.cnt = i_count; // reload for next edge
		end else if (!db_reg.out) begin
			if (db_reg.cnt == '0) begin
				db_next.out = 1'b1;
			end else if (i_tick) begin
				db_next.cnt = db_reg.cnt - 1'b1;
			end
		end
	end

	// a pulse shorter than the delay never reaches out
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			db_reg <= '0;
		end else begin
			db_reg <= db_next;
		end
	end

	assign o_out = db_reg.out;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_no_fall_delay;
		!i_sig |=> !o_out;
	endproperty
	a_no_fall_delay: assert property (p_no_fall_delay) else $error("output lagged a falling edge");

	property p_rise_delayed;
		(i_en && $rose(i_sig) && i_count != '0) |=> !o_out [*2];
	endproperty
	a_rise_delayed: assert property (p_rise_delayed) else $error("dead band not applied");
endmodule // bpw_deadband
`default_nettype wire

// ===== bpw_pkg.sv
// package for the bridge pwm steering and shutdown block
// What this block does
// - half-bridge drives pwm on A, complement on B
// - delay longer than duty keeps output inactive
// - forward: A active, D modulated, B C inactive
// - reverse: C active, B modulated, A D inactive
// - new direction takes effect next pwm period
// - during change modulated off, unmodulated pair swapped
// - full-bridge modes use no dead band
// - two low mode bits set pair polarities
// - flag set when second period begins after enable
// - three-bit field selects comparator or fault triggers
// - firmware setting status bit forces shutdown
// - status bit 7 sticks until cleared or restart
// - shutdown forces pin states at once, unclocked
// - each pair: low, high or high impedance
// - shutdown is level driven, lasts while asserted
// - status writes ignored while condition present
// - after restart output resumes at next period
// - dead band only on inactive to active edge
// - auto restart clears status when condition leaves
// - first enable waits for a new period start
package bpw_pkg;
	// register byte offsets on the avalon slave
	localparam logic [7:0] BPW_OFF_UNIT_CTL = 8'h00;
	localparam logic [7:0] BPW_OFF_DEAD_BAND = 8'h04;
	localparam logic [7:0] BPW_OFF_AUTO_SD = 8'h08;
	localparam logic [7:0] BPW_OFF_DRIVER_EN = 8'h0c;
	localparam logic [7:0] BPW_OFF_STATUS = 8'h10;
	// reset values
	localparam logic [7:0] BPW_RST_UNIT_CTL = 8'h00;
	localparam logic [7:0] BPW_RST_DEAD_BAND = 8'h00;
	localparam logic [7:0] BPW_RST_AUTO_SD = 8'h00;
	localparam logic [3:0] BPW_RST_DRIVER_EN = 4'h0;
	// unit_control fields
	localparam int BPW_MODE_MSB = 7; // output_mode_field
	localparam int BPW_MODE_LSB = 6;
	localparam int BPW_DIR_BIT = 7; // bridge_direction_bit
	localparam int BPW_SEL_MSB = 3; // mode_select_field
	localparam int BPW_SEL_LSB = 0;
	localparam int BPW_POL_AC_BIT = 1; // pair a/c active low
	localparam int BPW_POL_BD_BIT = 0; // pair b/d active low
	localparam logic [1:0] BPW_PWM_SEL = 2'h3; // mode_select_field[3:2] for pwm
	// dead_band_control fields
	localparam int BPW_RESTART_BIT = 7;
	localparam int BPW_DBC_MSB = 6;
	// auto_shutdown_control fields
	localparam int BPW_SD_STATUS_BIT = 7;
	localparam int BPW_SRC_MSB = 6;
	localparam int BPW_SRC_LSB = 4;
	localparam int BPW_PSS_AC_MSB = 3;
	localparam int BPW_PSS_AC_LSB = 2;
	localparam int BPW_PSS_BD_MSB = 1;
	localparam int BPW_PSS_BD_LSB = 0;
	// output modes
	localparam logic [1:0] BPW_OM_SINGLE = 2'h0;
	localparam logic [1:0] BPW_OM_FWD = 2'h1;
	localparam logic [1:0] BPW_OM_HALF = 2'h2;
	localparam logic [1:0] BPW_OM_REV = 2'h3;
	// oscillator periods per instruction cycle, the dead band unit
	localparam int BPW_OSC_PER_TCY = 4;
	localparam int BPW_DBC_WIDTH = 7;
	// enable sequencing states
	typedef enum logic [1:0] {
		BPW_ST_OFF = 2'b00,
		BPW_ST_WAIT = 2'b01,
		BPW_ST_RUN = 2'b10
	} bpw_state_t;
endpackage

// ===== bpw_switch_model.sv
// model of the power switch drivers hanging on the bridge pins
`timescale 1ns/1ps
`default_nettype none
module bpw_switch_model (
	input wire logic [3:0] i_pin, // pin levels, d c b a
	input wire logic [3:0] i_oe, // pin drive enables, d c b a
	output logic [3:0] o_wire, // resolved wire levels
	output logic o_shoot // both switches of one leg on
);
	// released pins fall to the board pull-downs, so switches stay off
	assign o_wire = i_pin & i_oe;
	// legs a/b and c/d, active-high gates assumed
	assign o_shoot = (o_wire[0] & o_wire[1]) | (o_wire[2] & o_wire[3]);
endmodule // bpw_switch_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for the bridge steering and shutdown block
`timescale 1ns/1ps
`default_nettype none
module tb import bpw_pkg::*; ;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] adr = 8'h00; // avalon address
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdata;
	logic waitreq;
	logic [2:0] cond = 3'h0; // fault, comparator two, comparator one
	logic [5:0] cnt = 6'h00; // period timer stand-in
	logic [5:0] duty = 6'h14; // half of a 40 clock period
	logic pwm;
	logic ps;
	logic a, b, c, d, aoe, boe, coe, doe, flag, shoot;
	logic [3:0] wire_lvl; // levels seen by the switches
	logic wq; // waitrequest as the next edge samples it
	logic [31:0] rq; // read data as the next edge samples it
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int na;
	int ns;
	logic [2:0] s;
	logic [31:0] q;

	// free running clock, 100 ns period
	initial begin
		forever #50 i_clk = ~i_clk;
	end

	// period counter gives the raw duty wave and period start pulse
	always @(posedge i_clk) begin
		cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
	end
	assign pwm = cnt < duty;
	assign ps = cnt == 6'h00;

	// settled bus values, stable up to the next rising edge
	always @(negedge i_clk) begin
		wq = waitreq;
		rq = rdata;
	end

	bpw_bridge uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_pwm(pwm),
		.i_period_start(ps), .i_fault_input_pin_n(~cond[2]),
		.i_comparator_one_output(cond[0]), .i_comparator_two_output(cond[1]),
		.o_out_a(a), .o_out_a_oe(aoe), .o_out_b(b), .o_out_b_oe(boe),
		.o_out_c(c), .o_out_c_oe(coe), .o_out_d(d), .o_out_d_oe(doe),
		.o_period_timer_a_match_flag(flag));

	bpw_switch_model sw (.i_pin({d, c, b, a}), .i_oe({doe, coe, boe, aoe}),
		.o_wire(wire_lvl), .o_shoot(shoot));

	// verdict and end of run
	task automatic wrap_up;
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// hang guard, far above the expected run length
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	// one comparison, counted
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic av(input logic w, input logic [7:0] ad, input logic [31:0] dt,
		output logic [31:0] qo);
		@(posedge i_clk);
		adr <= ad;
		wd <= dt;
		wr <= w;
		rd <= ~w;
		// only the hang guard ends a wait for the answer
		do begin
			@(posedge i_clk);
		end while (wq !== 1'b0);
		qo = rq;
		wr <= 1'b0;
		rd <= 1'b0;
		// let the landing edge settle before pins are looked at
		#1;
	endtask

	task automatic wreg(input logic [7:0] ad, input logic [31:0] dt);
		logic [31:0] dummy;
		av(1'b1, ad, dt, dummy);
	endtask

	task automatic creg(input string nm, input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] v;
		av(1'b0, ad, 32'h0000_0000, v);
		chk(nm, v, exp);
	endtask

	// wait for a given count of the period timer, just past the edge
	task automatic at(input logic [5:0] k);
		do begin
			@(posedge i_clk);
			#1;
		end while (cnt != k);
	endtask

	// pin levels a b c d, msb first
	task automatic cpin(input logic [3:0] exp);
		chk("pins", {28'h0000_000, a, b, c, d}, {28'h0000_000, exp});
	endtask

	// a and shoot-through cycles over one whole period
	task automatic per;
		na = 0;
		ns = 0;
		repeat (40) begin
			@(posedge i_clk);
			#1;
			na += int'(a);
			ns += int'(shoot);
		end
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		// first request one edge after reset is seen released
		@(posedge i_clk);
		// reset values, and an unmapped place that must stay empty
		wreg(8'h14, 32'h0000_00ff);
		for (int i = 0; i < 4; i++) creg("reset", 8'(i * 4), 32'h0000_0000);
		creg("unmapped", 8'h14, 32'h0000_0000);
		wreg(BPW_OFF_DEAD_BAND, 32'h0000_0002);
		creg("dead_band_control", BPW_OFF_DEAD_BAND, 32'h0000_0002);
		// forward mode; output waits for a period start
		at(6'h05);
		wreg(BPW_OFF_UNIT_CTL, 32'h0000_004c);
		cpin(4'b0000);
		at(6'h01);
		chk("match flag", {31'h0000_0000, flag}, 32'h0000_0000);
		at(6'h01);
		chk("match flag", {31'h0000_0000, flag}, 32'h0000_0001);
		creg("status", BPW_OFF_STATUS, 32'h0000_0021);
		// drivers only after a full cycle
		wreg(BPW_OFF_DRIVER_EN, 32'h0000_000f);
		at(6'h04);
		cpin(4'b1001);
		at(6'h1e);
		cpin(4'b1000);
		// direction change in mid period, duty far below full
		at(6'h03);
		wreg(BPW_OFF_UNIT_CTL, 32'h0000_00cc);
		@(posedge i_clk);
		#1;
		cpin(4'b0010);
		at(6'h04);
		cpin(4'b0110);
		at(6'h1e);
		cpin(4'b0010);
		// polarity per pair, only with the drivers off
		wreg(BPW_OFF_DRIVER_EN, 32'h0000_0000);
		wreg(BPW_OFF_UNIT_CTL, 32'h0000_00cf);
		at(6'h04);
		cpin(4'b1001);
		wreg(BPW_OFF_UNIT_CTL, 32'h0000_00ce);
		at(6'h04);
		cpin(4'b1100);
		// half bridge with a dead band of two instruction cycles
		wreg(BPW_OFF_UNIT_CTL, 32'h0000_008c);
		at(6'h04);
		cpin(4'b0000);
		at(6'h10);
		cpin(4'b1000);
		at(6'h18);
		cpin(4'b0000);
		at(6'h26);
		cpin(4'b0100);
		// drivers back on after a full half-bridge period
		wreg(BPW_OFF_DRIVER_EN, 32'h0000_000f);
		at(6'h00);
		per();
		chk("shoot cycles", ns, 32'h0000_0000);
		// a dead band longer than the duty
		wreg(BPW_OFF_DEAD_BAND, 32'h0000_000a);
		at(6'h00);
		per();
		chk("active cycles", na, 32'h0000_0000);
		wreg(BPW_OFF_DEAD_BAND, 32'h0000_0002);
		wreg(BPW_OFF_UNIT_CTL, 32'h0000_004c);
		// every source: a foreign level is ignored, a selected one trips
		for (int i = 1; i < 8; i++) begin
			s = i[2:0];
			wreg(BPW_OFF_AUTO_SD, {25'h0, s, 4'h1});
			if (s != 3'h7) begin
				@(posedge i_clk);
				cond <= ~s & (s + 3'h1);
				repeat (2) @(posedge i_clk);
				creg("no trip", BPW_OFF_AUTO_SD, {25'h0, s, 4'h1});
				@(posedge i_clk);
				cond <= 3'h0;
			end
			at(6'h05);
			@(posedge i_clk);
			cond <= s & (~s + 3'h1);
			#1;
			cpin(4'b0101);
			creg("tripped", BPW_OFF_AUTO_SD, {25'h1, s, 4'h1});
			wreg(BPW_OFF_AUTO_SD, {25'h0, s, 4'h1});
			creg("clear held", BPW_OFF_AUTO_SD, {25'h1, s, 4'h1});
			@(posedge i_clk);
			cond <= 3'h0;
			wreg(BPW_OFF_AUTO_SD, {25'h0, s, 4'h1});
			cpin(4'b0101);
			at(6'h04);
			cpin(4'b1001);
		end
		// high impedance shutdown state on both pairs
		@(posedge i_clk);
		cond <= 3'h4;
		wreg(BPW_OFF_AUTO_SD, 32'h0000_007a);
		chk("oe", {28'h0000_000, aoe, boe, coe, doe}, 32'h0000_0000);
		chk("wires", {28'h0000_000, wire_lvl}, 32'h0000_0000);
		@(posedge i_clk);
		cond <= 3'h0;
		wreg(BPW_OFF_AUTO_SD, 32'h0000_007a);
		at(6'h04);
		cpin(4'b1001);
		// firmware sets the status bit itself
		wreg(BPW_OFF_AUTO_SD, 32'h0000_0091);
		cpin(4'b0101);
		creg("firmware trip", BPW_OFF_AUTO_SD, 32'h0000_0091);
		// automatic restart clears status once the level goes away
		wreg(BPW_OFF_DEAD_BAND, 32'h0000_0082);
		wreg(BPW_OFF_AUTO_SD, 32'h0000_0011);
		@(posedge i_clk);
		cond <= 3'h1;
		repeat (3) @(posedge i_clk);
		cond <= 3'h0;
		repeat (3) @(posedge i_clk);
		creg("auto restart", BPW_OFF_AUTO_SD, 32'h0000_0011);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
